// file: verilog/asrc_cfg.svh
// timing and geometry constants for the static memory port controller
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH

`define ASRC_CLK_NS 20
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8
// fast grade figures in ns
`define ASRC_READ_CYCLE_MIN_NS 55
`define ASRC_ADDRESS_ACCESS_MAX_NS 55
`define ASRC_SELECT_ACCESS_MAX_NS 55
`define ASRC_OUTPUT_DRIVE_ACCESS_MAX_NS 25
`define ASRC_DRIVE_OFF_AFTER_OUTPUT_HIGH_NS 20
`define ASRC_DRIVE_OFF_AFTER_STROBE_LOW_NS 20
`define ASRC_WRITE_CYCLE_MIN_NS 55
`define ASRC_ADDRESS_SETUP_TO_END_NS 45
`define ASRC_WRITE_PULSE_WIDTH_MIN_NS 40
`define ASRC_DATA_SETUP_TO_END_NS 30
`define ASRC_POWER_DOWN_DELAY_NS 55
// least times round up to whole cycles
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_READ_CYC `ASRC_CYC(`ASRC_READ_CYCLE_MIN_NS + `ASRC_CLK_NS)
`define ASRC_TURN_CYC `ASRC_CYC(`ASRC_DRIVE_OFF_AFTER_OUTPUT_HIGH_NS)
`define ASRC_PULSE_CYC `ASRC_CYC(`ASRC_WRITE_PULSE_WIDTH_MIN_NS)
`define ASRC_DSETUP_CYC `ASRC_CYC(`ASRC_DATA_SETUP_TO_END_NS)
`define ASRC_WCYC_CYC `ASRC_CYC(`ASRC_WRITE_CYCLE_MIN_NS)
`define ASRC_CNT_W 4

`endif

// file: verilog/asrc_pkg.sv
// types for the static memory port controller
package asrc_pkg;
	typedef enum logic [2:0] {
		ASRC_IDLE,
		ASRC_RD_WAIT,
		ASRC_WR_TURN,
		ASRC_WR_PULSE,
		ASRC_WR_END,
		ASRC_GAP
	} asrc_state_t;
endpackage : asrc_pkg

// file: verilog/asrc_cnt.sv
// down counter that tells when a programmed number of cycles has passed
`timescale 1ns/1ns
module asrc_cnt
	import asrc_pkg::*;
#(
	parameter int W = 4
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// control
	input wire logic load_i,
	input wire logic [W-1:0] value_i,
	// status
	output logic done_o
);
	typedef struct packed {
		logic [W-1:0] count;
	} asrc_cnt_t;

	asrc_cnt_t st;
	asrc_cnt_t next_st;

	always_comb
	begin
		next_st = st;
		if (load_i)
			next_st.count = value_i;
		else if (st.count != '0)
			next_st.count = st.count - 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
			st <= '0;
		else
			st <= next_st;
	end

	// done must not look at load: the caller reloads on done, and that would close a combinational loop
	assign done_o = (st.count == '0);
endmodule : asrc_cnt

// file: verilog/asrc_ctrl.sv
// host controller that runs read and write cycles on an asynchronous 32k x 8 static memory
`timescale 1ns/1ns
`include "asrc_cfg.svh"

// What this block does
// - read data sampled only after read cycle time; next read waits that long
// - address stays stable from write start to end, above setup-to-end time
// - address is driven before or with the start of the write
// - address stays unchanged until the write-ending edge
// - write data driven at least the setup time before strobe rises
// - write data held through the ending edge and one cycle after
// - write ended by strobe rising, select rising one cycle later
// - data setup and hold counted from the strobe rising edge
// - write cycle covers turn-off time after strobe falls plus data setup
// - bus not driven until memory output turn-off time has passed
// - address valid at or before select falls on reads
module asrc_ctrl
	import asrc_pkg::*;
#(
	parameter int ADDR_W = `ASRC_ADDR_W,
	parameter int DATA_W = `ASRC_DATA_W
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// user request
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [DATA_W-1:0] rsp_rdata_o,
	// memory pins
	output logic [ADDR_W-1:0] word_address_o,
	output logic select_n_o,
	output logic write_strobe_n_o,
	output logic output_drive_n_o,
	input wire logic [DATA_W-1:0] data_bus_i,
	output logic [DATA_W-1:0] data_bus_o,
	output logic data_bus_oe_o
);
	typedef struct packed {
		asrc_state_t state;
		logic ready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [ADDR_W-1:0] addr;
		logic sel_n;
		logic we_n;
		logic oe_n;
		logic [DATA_W-1:0] dout;
		logic doe;
	} asrc_ctrl_t;

	asrc_ctrl_t st;
	asrc_ctrl_t next_st;
	logic cnt_load;
	logic [`ASRC_CNT_W-1:0] cnt_value;
	logic cnt_done;

	asrc_cnt #(
		.W(`ASRC_CNT_W)
	) u_cnt (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.load_i(cnt_load),
		.value_i(cnt_value),
		.done_o(cnt_done)
	);

	always_comb
	begin
		next_st = st;
		next_st.rvalid = 1'b0;
		cnt_load = 1'b0;
		cnt_value = '0;
		case (st.state)
			ASRC_IDLE:
			begin
				if (req_i && st.ready)
				begin
					next_st.ready = 1'b0;
					next_st.addr = req_addr_i;
					next_st.sel_n = 1'b0;
					cnt_load = 1'b1;
					if (req_write_i)
					begin
						next_st.oe_n = 1'b1;
						next_st.we_n = 1'b0;
						next_st.dout = req_wdata_i;
						next_st.state = ASRC_WR_TURN;
						cnt_value = `ASRC_CNT_W'(`ASRC_TURN_CYC);
					end
					else
					begin
						next_st.oe_n = 1'b0;
						next_st.state = ASRC_RD_WAIT;
						cnt_value = `ASRC_CNT_W'(`ASRC_READ_CYC);
					end
				end
			end
			ASRC_RD_WAIT:
			begin
				if (cnt_done)
				begin
					// sampling a full cycle past access time leaves the 5 ns hold as margin
					next_st.rdata = data_bus_i;
					next_st.rvalid = 1'b1;
					next_st.sel_n = 1'b1;
					next_st.oe_n = 1'b1;
					next_st.state = ASRC_GAP;
				end
			end
			ASRC_WR_TURN:
			begin
				if (cnt_done)
				begin
					next_st.doe = 1'b1;
					cnt_load = 1'b1;
					cnt_value = `ASRC_CNT_W'(`ASRC_DSETUP_CYC);
					next_st.state = ASRC_WR_PULSE;
				end
			end
			ASRC_WR_PULSE:
			begin
				if (cnt_done)
				begin
					next_st.we_n = 1'b1;
					next_st.state = ASRC_WR_END;
				end
			end
			ASRC_WR_END:
			begin
				next_st.sel_n = 1'b1;
				next_st.doe = 1'b0;
				next_st.state = ASRC_GAP;
			end
			ASRC_GAP:
			begin
				next_st.ready = 1'b1;
				next_st.state = ASRC_IDLE;
			end
			default:
				next_st.state = ASRC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rstn_i)
		begin
			st <= '0;
			st.state <= ASRC_IDLE;
			st.ready <= 1'b1;
			st.sel_n <= 1'b1;
			st.we_n <= 1'b1;
			st.oe_n <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign req_ready_o = st.ready;
	assign rsp_valid_o = st.rvalid;
	assign rsp_rdata_o = st.rdata;
	assign word_address_o = st.addr;
	assign select_n_o = st.sel_n;
	assign write_strobe_n_o = st.we_n;
	assign output_drive_n_o = st.oe_n;
	assign data_bus_o = st.dout;
	assign data_bus_oe_o = st.doe;

	// strobe low at least the pulse width and data driven for the setup time
	int unsigned we_low_cnt;
	int unsigned d_cnt;
	always_ff @(posedge clk_sys_i)
	begin
		we_low_cnt <= (!rstn_i || st.we_n) ? 0 : we_low_cnt + 1;
		d_cnt <= (!rstn_i || !st.doe) ? 0 : d_cnt + 1;
	end

	pulse_width_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(st.we_n) |-> $past(we_low_cnt) >= 3)
		else $error("write strobe pulse too short");
	data_setup_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(st.we_n) |-> $past(d_cnt) >= 2 && st.doe)
		else $error("write data setup too short");
	addr_stable_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		!st.we_n |=> $stable(st.addr))
		else $error("address moved during write");
	no_contention_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		st.doe |-> st.oe_n && !st.sel_n)
		else $error("bus driven while memory may drive");
	no_joint_rise_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(st.we_n) |-> !st.sel_n ##1 st.sel_n)
		else $error("select rose with strobe");
	data_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$rose(st.we_n) |-> st.doe && $stable(st.dout))
		else $error("write data not held");
	read_time_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(st.sel_n) && !st.oe_n |-> !rsp_valid_o [*4])
		else $error("read sampled too early");
	standby_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		st.state == ASRC_GAP |-> st.sel_n && st.oe_n && st.we_n && !st.doe)
		else $error("memory not released between accesses");
	read_sample_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		$fell(st.sel_n) && !st.oe_n |-> ##5 st.rvalid)
		else $error("read data not returned on time");
endmodule : asrc_ctrl

// file: sim/asrc_mem_model.sv
// behavioural 32k x 8 static memory answering the controller
`timescale 1ns/1ns
module asrc_mem_model (
	// memory pins
	input wire logic [14:0] word_address_i,
	input wire logic select_n_i,
	input wire logic write_strobe_n_i,
	input wire logic output_drive_n_i,
	// controller side of the bus and the resolved level
	input wire logic [7:0] bus_i,
	input wire logic bus_oe_i,
	output logic [7:0] data_o
);
	logic [7:0] mem [0:32767];
	logic [7:0] last = 8'h00;
	wire drv;
	// output comes up only after the slowest access time, so early sampling sees junk
	assign #55 drv = !select_n_i && !output_drive_n_i && write_strobe_n_i;
	// a released bus shows the inverse of its last value rather than a stale copy
	assign data_o = bus_oe_i ? bus_i : (drv ? mem[word_address_i] : ~last);
	always @*
		if (drv)
			last = mem[word_address_i];
	// the write ends on whichever strobe rises first
	always @(posedge write_strobe_n_i)
		if (!select_n_i)
			mem[word_address_i] = data_o;
	always @(posedge select_n_i)
		if (!write_strobe_n_i)
			mem[word_address_i] = data_o;
endmodule : asrc_mem_model

// file: sim/asrc_ctrl_tb_top.sv
// self-checking bench for the static memory port controller
`timescale 1ns/1ns
module asrc_ctrl_tb_top;
	logic clk_sys_i = 0, rstn_i = 0, req_i = 0, req_write_i = 0;
	logic [14:0] req_addr_i = 0;
	logic [7:0] req_wdata_i = 0;
	logic req_ready_o, rsp_valid_o, select_n_o, write_strobe_n_o, output_drive_n_o, data_bus_oe_o;
	logic [7:0] rsp_rdata_o, data_bus_o, bus;
	logic [14:0] word_address_o;
	int n_errors = 0, check_count = 0, cycles = 0;
	always #10 clk_sys_i = ~clk_sys_i;
	asrc_ctrl asrc_ctrl_inst (.clk_sys_i, .rstn_i, .req_i, .req_write_i, .req_addr_i, .req_wdata_i,
		.req_ready_o, .rsp_valid_o, .rsp_rdata_o, .word_address_o, .select_n_o, .write_strobe_n_o,
		.output_drive_n_o, .data_bus_i(bus), .data_bus_o, .data_bus_oe_o);
	asrc_mem_model asrc_mem_model_inst (.word_address_i(word_address_o), .select_n_i(select_n_o),
		.write_strobe_n_i(write_strobe_n_o), .output_drive_n_i(output_drive_n_o), .bus_i(data_bus_o),
		.bus_oe_i(data_bus_oe_o), .data_o(bus));
	task automatic end_sim;
		$display("checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step
	// ready seen just after an edge is what the next edge samples
	task automatic issue(input logic wr, input logic [14:0] a, input logic [7:0] d);
		req_i = 1;
		req_write_i = wr;
		req_addr_i = a;
		req_wdata_i = d;
		while (req_ready_o !== 1'b1)
			step();
		step();
		req_i = 0;
	endtask : issue
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		int low = 0, set = 0, held = 0;
		issue(1'b1, a, d);
		repeat (7)
		begin
			if (write_strobe_n_o === 1'b0)
			begin
				low++;
				if (data_bus_oe_o === 1'b1 && data_bus_o === d)
					set++;
				check("write pins", {word_address_o, select_n_o, output_drive_n_o}, {a, 2'b01});
			end
			else if (low > 0 && held == 0)
			begin
				held = 1;
				check("write end", {select_n_o, data_bus_oe_o, data_bus_o}, {2'b01, d});
			end
			step();
		end
		check("strobe width", 24'(low), 24'd5);
		check("data setup", 24'(set), 24'd3);
	endtask : wr
	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		int k = 1;
		issue(1'b0, a, 8'h00);
		check("read pins", {word_address_o, select_n_o, write_strobe_n_o, output_drive_n_o}, {a, 3'b010});
		while (rsp_valid_o !== 1'b1 && k < 12)
		begin
			step();
			k++;
		end
		check("read latency", 24'(k), 24'd6);
		check("read data", rsp_rdata_o, exp);
		check("deselect", {select_n_o, output_drive_n_o}, 2'b11);
		step();
		check("valid pulse", rsp_valid_o, 1'b0);
	endtask : rd
	// a write offered while a read is busy must leave memory untouched
	task automatic refused;
		issue(1'b0, 15'h0123, 8'h00);
		step();
		req_i = 1;
		req_write_i = 1;
		req_addr_i = 15'h0456;
		req_wdata_i = 8'hEE;
		step(3);
		req_i = 0;
		step();
		rd(15'h0456, 8'h5A);
	endtask : refused
	initial
	begin
		step(4);
		rstn_i = 1;
		check("reset pins", {req_ready_o, select_n_o, write_strobe_n_o, output_drive_n_o, data_bus_oe_o,
			rsp_valid_o}, 6'b111100);
		wr(15'h0000, 8'hA5);
		wr(15'h7FFF, 8'h3C);
		wr(15'h4000, 8'hFF);
		wr(15'h0456, 8'h5A);
		rd(15'h7FFF, 8'h3C);
		rd(15'h0000, 8'hA5);
		rd(15'h4000, 8'hFF);
		wr(15'h0000, 8'h00);
		rd(15'h0000, 8'h00);
		refused();
		end_sim();
	end
endmodule : asrc_ctrl_tb_top
